// >>> fbf_pkg.sv
// package: register map, field layout and reset values for fifo and framing
package fbf_pkg;
  localparam logic [5:0] ADDR_BYTE_PORT = 6'h09;
  localparam logic [5:0] ADDR_FILL_COUNT = 6'h0A;
  localparam logic [5:0] ADDR_WATERMARK = 6'h0B;
  localparam logic [5:0] ADDR_MISC_CTRL = 6'h0C;
  localparam logic [5:0] ADDR_BIT_FRAME = 6'h0D;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h20;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h21;
  localparam int BIT_QUEUE_CLEAR = 7;
  localparam int BIT_TIMER_HALT = 7;
  localparam int BIT_TIMER_GO = 6;
  localparam int BIT_TX_TRIGGER = 7;
  localparam int LSB_RX_OFFSET = 4;
  localparam int LSB_TX_FINAL = 0;
  localparam logic [5:0] WATERMARK_RST = 6'h08;
  localparam logic [7:0] MISC_CTRL_RST = 8'h10;
  localparam logic [2:0] LINK_IDLE = 3'h0;
  localparam logic [2:0] LINK_WAIT_TRIGGER = 3'h1;
  localparam logic [2:0] LINK_TRANSMIT = 3'h3;
  localparam logic [2:0] LINK_RECEIVE = 3'h6;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_LOW_ALERT = 1;
  localparam int IRQ_RX_DONE = 2;
endpackage

// >>> fbf_top.sv
// fifo, level, watermark alert, timer strobes and bit framing control
//
// Design decision made here: the address-and-strobe port.
module fbf_top #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic [5:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_TRANSCEIVE,
  output logic [2:0] O_LINK_STATE,
  output logic O_TIMER_HALT,
  output logic O_TIMER_GO,
  output logic [2:0] O_TX_FINAL_BITS,
  output logic O_TX_VALID,
  output logic [7:0] O_TX_DATA,
  input wire logic I_TX_READY,
  input wire logic I_TX_DONE,
  input wire logic I_RX_BIT_VALID,
  input wire logic I_RX_BIT,
  input wire logic I_RX_END,
  output logic O_LOW_FILL_ALERT,
  output logic O_OVERFLOW,
  output logic O_IRQ
);
  import fbf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TX, ST_RX} fbf_link_e;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [6:0] level;
    logic ovf;
    logic [5:0] watermark;
    logic [2:0] rx_offset;
    logic [2:0] tx_final;
    logic [2:0] rx_final_valid;
    logic [7:0] rdata;
    logic halt;
    logic go;
    fbf_link_e link;
    logic [7:0] rx_shift;
    logic [2:0] rx_pos;
    logic rx_any;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic low_prev;
  } fbf_state_s;

  fbf_state_s st_reg;
  fbf_state_s st_next;
  logic [7:0] mem [DEPTH];

  logic full;
  logic empty;
  logic host_push;
  logic host_pop;
  logic rx_push;
  logic tx_pop;
  logic do_push;
  logic do_pop;
  logic push_ok;
  logic pop_ok;
  logic clear;
  logic low_alert;
  logic [7:0] rx_byte;
  logic rx_byte_done;
  logic [6:0] level_ext_wm;
  logic [AW-1:0] ptr_one;

  // level flags
  assign full = st_reg.level == 7'(DEPTH);
  assign empty = st_reg.level == 7'h00;
  assign level_ext_wm = {1'b0, st_reg.watermark};
  assign low_alert = st_reg.level <= level_ext_wm;
  assign ptr_one = AW'(1);

  // fifo access sources, host and link share the same pointers
  assign host_push = I_WR && I_ADDR == ADDR_BYTE_PORT;
  assign host_pop = I_RD && I_ADDR == ADDR_BYTE_PORT;
  assign clear = I_WR && I_ADDR == ADDR_FILL_COUNT
    && I_WDATA[BIT_QUEUE_CLEAR];
  assign tx_pop = st_reg.link == ST_TX && !st_reg.tx_valid && !empty;
  assign do_push = host_push || rx_push;
  assign do_pop = host_pop || tx_pop;
  assign push_ok = do_push && !full;
  assign pop_ok = do_pop && !empty;

  // receive bit assembly with start offset
  always_comb
  begin
    rx_byte = st_reg.rx_shift;
    // only a qualified bit lands; the idle line must not leak into a
    // partial byte pushed at frame end
    if (I_RX_BIT_VALID)
      rx_byte[st_reg.rx_pos] = I_RX_BIT;
    rx_byte_done = st_reg.link == ST_RX && I_RX_BIT_VALID
      && st_reg.rx_pos == 3'h7;
    rx_push = rx_byte_done || (st_reg.link == ST_RX && I_RX_END
      && st_reg.rx_any);
  end

  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.halt = 1'b0;
    st_next.go = 1'b0;
    st_next.low_prev = low_alert;
    // pointers and level
    if (clear)
    begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.level = 7'h00;
    end
    else
    begin
      if (push_ok)
        st_next.wr_ptr = st_reg.wr_ptr + ptr_one;
      if (pop_ok)
        st_next.rd_ptr = st_reg.rd_ptr + ptr_one;
      if (push_ok && !pop_ok)
        st_next.level = st_reg.level + 7'h01;
      else if (pop_ok && !push_ok)
        st_next.level = st_reg.level - 7'h01;
    end
    if (do_push && full && !pop_ok)
      st_next.ovf = 1'b1;
    else if (clear)
      st_next.ovf = 1'b0;
    // read data, one cycle after the strobe
    st_next.rdata = 8'h00;
    if (I_RD)
    begin
      case (I_ADDR)
        ADDR_BYTE_PORT: st_next.rdata = mem[st_reg.rd_ptr];
        ADDR_FILL_COUNT: st_next.rdata = {1'b0, st_reg.level};
        ADDR_WATERMARK: st_next.rdata = {2'b00, st_reg.watermark};
        ADDR_MISC_CTRL: st_next.rdata = {5'h02, st_reg.rx_final_valid};
        ADDR_BIT_FRAME: st_next.rdata = {1'b0, st_reg.rx_offset, 1'b0,
          st_reg.tx_final};
        ADDR_IRQ_STATUS: st_next.rdata = {5'h00, st_reg.irq_status};
        ADDR_IRQ_MASK: st_next.rdata = {5'h00, st_reg.irq_mask};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // register writes
    if (I_WR)
    begin
      case (I_ADDR)
        ADDR_WATERMARK: st_next.watermark = I_WDATA[5:0];
        ADDR_MISC_CTRL:
        begin
          st_next.halt = I_WDATA[BIT_TIMER_HALT];
          st_next.go = I_WDATA[BIT_TIMER_GO];
        end
        ADDR_BIT_FRAME:
        begin
          st_next.rx_offset = I_WDATA[LSB_RX_OFFSET +: 3];
          st_next.tx_final = I_WDATA[LSB_TX_FINAL +: 3];
        end
        ADDR_IRQ_MASK: st_next.irq_mask = I_WDATA[2:0];
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end
    // link sequence
    case (st_reg.link)
      ST_IDLE:
        if (I_TRANSCEIVE)
          st_next.link = ST_WAIT;
      ST_WAIT:
        if (!I_TRANSCEIVE)
          st_next.link = ST_IDLE;
        else if (I_WR && I_ADDR == ADDR_BIT_FRAME
          && I_WDATA[BIT_TX_TRIGGER])
          st_next.link = ST_TX;
      ST_TX:
      begin
        if (tx_pop)
        begin
          st_next.tx_data = mem[st_reg.rd_ptr];
          st_next.tx_valid = 1'b1;
        end
        else if (st_reg.tx_valid && I_TX_READY)
          st_next.tx_valid = 1'b0;
        if (I_TX_DONE)
        begin
          st_next.link = ST_RX;
          st_next.tx_valid = 1'b0;
          st_next.rx_shift = 8'h00;
          st_next.rx_pos = st_reg.rx_offset;
          st_next.rx_any = 1'b0;
        end
      end
      ST_RX:
      begin
        if (I_RX_BIT_VALID)
        begin
          st_next.rx_shift = rx_byte_done ? 8'h00 : rx_byte;
          st_next.rx_pos = st_reg.rx_pos + 3'h1;
          st_next.rx_any = !rx_byte_done;
          st_next.rx_final_valid = st_reg.rx_pos + 3'h1;
        end
        if (I_RX_END)
        begin
          st_next.link = I_TRANSCEIVE ? ST_WAIT : ST_IDLE;
          st_next.rx_any = 1'b0;
        end
      end
      default: st_next.link = ST_IDLE;
    endcase
    // sticky events, set wins over write-one clear
    if (I_WR && I_ADDR == ADDR_IRQ_STATUS)
      st_next.irq_status = st_reg.irq_status & ~I_WDATA[2:0];
    if (do_push && full && !pop_ok)
      st_next.irq_status[IRQ_OVERFLOW] = 1'b1;
    if (low_alert && !st_reg.low_prev)
      st_next.irq_status[IRQ_LOW_ALERT] = 1'b1;
    if (st_reg.link == ST_RX && I_RX_END)
      st_next.irq_status[IRQ_RX_DONE] = 1'b1;
  end

  // state register with clock enable
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      st_reg <= '0;
      st_reg.watermark <= WATERMARK_RST;
      st_reg.rx_final_valid <= MISC_CTRL_RST[2:0];
      st_reg.low_prev <= 1'b1;
    end
    else if (I_CE)
      st_reg <= st_next;
  end

  // byte storage, no reset needed
  always_ff @(posedge I_CLK)
  begin
    if (I_CE && push_ok && !clear)
      mem[st_reg.wr_ptr] <= host_push ? I_WDATA : rx_byte;
  end

  // outputs
  always_comb
  begin
    case (st_reg.link)
      ST_WAIT: O_LINK_STATE = LINK_WAIT_TRIGGER;
      ST_TX: O_LINK_STATE = LINK_TRANSMIT;
      ST_RX: O_LINK_STATE = LINK_RECEIVE;
      default: O_LINK_STATE = LINK_IDLE;
    endcase
  end
  assign O_RDATA = st_reg.rdata;
  assign O_TIMER_HALT = st_reg.halt;
  assign O_TIMER_GO = st_reg.go;
  assign O_TX_FINAL_BITS = st_reg.tx_final;
  assign O_TX_VALID = st_reg.tx_valid;
  assign O_TX_DATA = st_reg.tx_data;
  assign O_LOW_FILL_ALERT = low_alert;
  assign O_OVERFLOW = st_reg.ovf;
  assign O_IRQ = |(st_reg.irq_status & st_reg.irq_mask);
endmodule

// >>> fbf_props.sv
// checker: port timing relations of the fifo and framing block
module fbf_props
  import fbf_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic [5:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_TRANSCEIVE,
  input wire logic I_RX_BIT_VALID,
  input wire logic I_RX_END,
  input wire logic [7:0] O_RDATA,
  input wire logic [2:0] O_LINK_STATE,
  input wire logic O_TIMER_HALT,
  input wire logic O_TIMER_GO,
  input wire logic [2:0] O_TX_FINAL_BITS,
  input wire logic O_OVERFLOW
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // accepted write and trigger write
  logic w;
  logic trg;
  assign w = I_CE && I_WR;
  assign trg = w && I_ADDR == ADDR_BIT_FRAME && I_WDATA[BIT_TX_TRIGGER];
  clear_reads_zero_a: assert property (I_CE && I_RD &&
    I_ADDR == ADDR_FILL_COUNT |=> !O_RDATA[BIT_QUEUE_CLEAR])
    else $error("clear bit read back as one");
  strobes_read_zero_a: assert property (I_CE && I_RD &&
    I_ADDR == ADDR_MISC_CTRL |=> O_RDATA[7:6] == 2'h0)
    else $error("timer strobe bits read back nonzero");
  halt_pulse_a: assert property (w && I_ADDR == ADDR_MISC_CTRL &&
    I_WDATA[BIT_TIMER_HALT] |=> O_TIMER_HALT)
    else $error("halt strobe missing");
  go_pulse_a: assert property (w && I_ADDR == ADDR_MISC_CTRL &&
    I_WDATA[BIT_TIMER_GO] |=> O_TIMER_GO)
    else $error("go strobe missing");
  clear_drops_ovf_a: assert property (w && I_ADDR == ADDR_FILL_COUNT &&
    I_WDATA[7] && !I_RX_BIT_VALID && !I_RX_END |=> !O_OVERFLOW)
    else $error("overflow kept after clear");
  tx_bits_a: assert property (w && I_ADDR == ADDR_BIT_FRAME
    |=> O_TX_FINAL_BITS == $past(I_WDATA[2:0]))
    else $error("final bit count not taken");
  wait_entry_a: assert property (I_CE && I_TRANSCEIVE &&
    O_LINK_STATE == LINK_IDLE |=> O_LINK_STATE == LINK_WAIT_TRIGGER)
    else $error("no wait state on transceive");
  wait_hold_a: assert property (I_CE && I_TRANSCEIVE && !trg &&
    O_LINK_STATE == LINK_WAIT_TRIGGER |=> O_LINK_STATE == LINK_WAIT_TRIGGER)
    else $error("wait state left without trigger");
  trigger_starts_a: assert property (trg && I_TRANSCEIVE &&
    O_LINK_STATE == LINK_WAIT_TRIGGER |=> O_LINK_STATE == LINK_TRANSMIT)
    else $error("trigger did not start sending");
  idle_trigger_a: assert property (trg && !I_TRANSCEIVE &&
    O_LINK_STATE == LINK_IDLE |=> O_LINK_STATE == LINK_IDLE)
    else $error("trigger acted without transceive");
endmodule

// >>> fbf_link_model.sv
// model of the modem side: takes transmit bytes, sends receive bits
module fbf_link_model (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready = 1'b0,
  output logic tx_done = 1'b0,
  output logic rx_bit_valid = 1'b0,
  output logic rx_bit = 1'b0,
  output logic rx_end = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got = 8'h00;
  // slow accept: ready one cycle late, done after the byte
  always_ff @(posedge clk)
  begin
    tx_ready <= tx_valid && !tx_ready;
    tx_done <= tx_valid && tx_ready;
    if (tx_valid && tx_ready)
      got <= tx_data;
  end
  // frame of n bits, lsb first; line flips when idle
  task automatic rx_frame(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rx_bit_valid <= 1'b1;
      rx_bit <= b[i];
    end
    @(posedge clk);
    rx_bit_valid <= 1'b0;
    rx_bit <= ~rx_bit;
    rx_end <= 1'b1;
    @(posedge clk);
    rx_end <= 1'b0;
  endtask
endmodule

// >>> fifo_and_bit_framing_control_bench.sv
// bench: register access scenarios for the fifo and framing block
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module fifo_and_bit_framing_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fbf_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, trx = 0;
  logic [5:0] addr = '0;
  logic [7:0] wdata = '0, rdata, txd, got;
  logic [2:0] lst, txf;
  logic rdy, done, rbv, rb, rend, txv, halt, go, low, ovf, irq;
  int failures = 0, check_count = 0;
  fbf_top uut (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_TRANSCEIVE(trx), .O_LINK_STATE(lst), .O_TIMER_HALT(halt),
    .O_TIMER_GO(go), .O_TX_FINAL_BITS(txf), .O_TX_VALID(txv),
    .O_TX_DATA(txd), .I_TX_READY(rdy), .I_TX_DONE(done),
    .I_RX_BIT_VALID(rbv), .I_RX_BIT(rb), .I_RX_END(rend),
    .O_LOW_FILL_ALERT(low), .O_OVERFLOW(ovf), .O_IRQ(irq));
  fbf_link_model link (.clk, .tx_valid(txv), .tx_data(txd), .tx_ready(rdy),
    .tx_done(done), .rx_bit_valid(rbv), .rx_bit(rb), .rx_end(rend));
  // clock
  initial forever #2.5 clk = ~clk;
  // bus cycles; results looked at once they have landed
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    rd_reg(a);
    `CHK("rdata", e, got)
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // scenarios
  initial
  begin
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_WATERMARK, 8'h08);
    rd_chk(ADDR_MISC_CTRL, MISC_CTRL_RST);
    rd_chk(ADDR_BIT_FRAME, 8'h00);
    rd_chk(6'h3F, 8'h00);
    for (n = 0; n < 3; n++) wr_reg(ADDR_BYTE_PORT, 8'hA0 + 8'(n));
    rd_chk(ADDR_FILL_COUNT, 8'h03);
    `CHK("low", 1'b1, low)
    wr_reg(ADDR_WATERMARK, 8'h02);
    `CHK("low", 1'b0, low)
    for (n = 0; n < 3; n++) rd_chk(ADDR_BYTE_PORT, 8'hA0 + 8'(n));
    rd_reg(ADDR_BYTE_PORT);
    rd_chk(ADDR_FILL_COUNT, 8'h00);
    for (n = 0; n < 65; n++) wr_reg(ADDR_BYTE_PORT, 8'(n));
    rd_chk(ADDR_FILL_COUNT, 8'h40);
    `CHK("ovf", 1'b1, ovf)
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    `CHK("irq", 1'b1, irq)
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    `CHK("irq", 1'b0, irq)
    wr_reg(ADDR_FILL_COUNT, 8'h80);
    rd_chk(ADDR_FILL_COUNT, 8'h00);
    `CHK("ovf", 1'b0, ovf)
    wr_reg(ADDR_MISC_CTRL, 8'hC0);
    rd_chk(ADDR_MISC_CTRL, 8'h10);
    wr_reg(ADDR_BIT_FRAME, 8'h75);
    `CHK("txf", 3'h5, txf)
    wr_reg(ADDR_BIT_FRAME, 8'hF5);
    rd_chk(ADDR_BIT_FRAME, 8'h75);
    @(posedge clk);
    trx <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("state", LINK_WAIT_TRIGGER, lst)
    wr_reg(ADDR_BYTE_PORT, 8'hA5);
    wr_reg(ADDR_BIT_FRAME, 8'hF0);
    for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk) #1;
    if (done !== 1'b1)
    begin
      failures++;
      end_of_test();
    end
    `CHK("tx byte", 8'hA5, link.got)
    @(posedge clk);
    trx <= 1'b0;
    link.rx_frame(16'h0303, 10);
    rd_chk(ADDR_FILL_COUNT, 8'h03);
    rd_chk(ADDR_MISC_CTRL, 8'h11);
    rd_reg(ADDR_BYTE_PORT);
    `CHK("first bit", 1'b1, got[7])
    rd_chk(ADDR_BYTE_PORT, 8'h81);
    rd_reg(ADDR_BYTE_PORT);
    `CHK("last bit", 1'b1, got[0])
    end_of_test();
  end
endmodule
bind fbf_top fbf_props chk (.I_CLK, .I_SYS_RST, .I_CE, .I_ADDR, .I_WDATA,
  .I_WR, .I_RD, .I_TRANSCEIVE, .I_RX_BIT_VALID, .I_RX_END, .O_RDATA,
  .O_LINK_STATE, .O_TIMER_HALT, .O_TIMER_GO, .O_TX_FINAL_BITS, .O_OVERFLOW);
